// file: pkg/cfr_capture_regs.svh
`ifndef CFR_CAPTURE_REGS_SVH
`define CFR_CAPTURE_REGS_SVH

// ----------------------------------------
// register offsets (13-bit serial bus address)
// ----------------------------------------
`define CFR_ADDR_SETTLE_LO 13'h0105
`define CFR_ADDR_SETTLE_HI 13'h0106
`define CFR_ADDR_READBACK 13'h0107
`define CFR_ADDR_FLAGS 13'h010a
`define CFR_ADDR_SAMPLE_LO 13'h010b
`define CFR_ADDR_SAMPLE_HI 13'h010c
`define CFR_ADDR_START_LO 13'h010f
`define CFR_ADDR_START_HI 13'h0110
`define CFR_ADDR_PDIV 13'h0111
`define CFR_ADDR_SDIV 13'h0112
`define CFR_ADDR_PATTERN 13'h013a

// ----------------------------------------
// reset values
// ----------------------------------------
`define CFR_RST_BYTE 8'h00
`define CFR_RST_DIV 5'h04
`define CFR_RST_PN 15'h7fff

// ----------------------------------------
// serial bus frame
// ----------------------------------------
`define CFR_RW_BIT 15
`define CFR_INSTR_LAST 5'h0f
`define CFR_FRAME_LAST 5'h17
`define CFR_DATA_FIRST 5'h10

// ----------------------------------------
// capture geometry and patterns
// ----------------------------------------
`define CFR_BLOCK_SHIFT 6
`define CFR_WORD_BITS 4'hc
`define CFR_TP_ONES 5'h06
`define CFR_TP_PLUS1 5'h05
`define CFR_TP_PN 5'h04
`define CFR_TP_CHK_A 5'h03
`define CFR_TP_CHK_5 5'h02
`define CFR_PAT_ONES 12'hfff
`define CFR_PAT_PLUS1 12'h001
`define CFR_PAT_CHK_A 12'haaa
`define CFR_PAT_CHK_5 12'h555

`endif

// file: pkg/cfr_pkg.sv
package cfr_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETTLE = 5'h02,
    ST_FILL = 5'h04,
    ST_FULL = 5'h08,
    ST_DUMP = 5'h10
  } cfr_state_t;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_PAR = 2'h1,
    MODE_SER = 2'h2,
    MODE_SLAVE = 2'h3
  } cfr_mode_t;

endpackage

// file: design/cfr_sample_mem.sv
`timescale 1ns/1ps

// capture memory, registered read port
module cfr_sample_mem (
  // clock
  input wire logic clock,
  input wire logic clk_en,
  // write port
  input wire logic wr_en,
  input wire logic [13:0] wr_addr,
  input wire logic [11:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic [13:0] rd_addr,
  output logic [11:0] rd_data
);

  logic [11:0] mem [0:16383];

  always_ff @(posedge clock) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (clk_en && rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// file: design/cfr_capture_ctrl.sv
`timescale 1ns/1ps
`include "cfr_capture_regs.svh"

// Notes on behaviour
// - 16-bit settling interval in low and high bytes, applied before a fill from standby.
// - readback mode 00 off, 01 parallel master, 10 serial master, 11 serial slave.
// - read-only status holds full and over-range flags, upper bits zero, reset zero.
// - 12-bit sample read as low byte plus upper nibble, high nibble zero.
// - 14-bit read start offset from low byte and six-bit high field.
// - parallel clock divides master clock by twice the field value.
// - test mode stores ones, plus one, noise or checkerboard instead of samples.
// - fill from standby powers converter up and waits settling count.
// - full flag rises after capture, then waits for a dump request.
// - each fill captures (block count plus one) times 64 samples.
module cfr_capture_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // configuration serial bus
  input wire logic cfg_csb_n,
  input wire logic cfg_sclk,
  input wire logic cfg_sdio_in,
  output logic cfg_sdio_out,
  output logic cfg_sdio_oe,
  // converter
  input wire logic [11:0] adc_data,
  input wire logic adc_over_range,
  output logic converter_power_up,
  // capture control
  input wire logic fill_pin,
  input wire logic dump_pin,
  input wire logic [7:0] capture_block_count,
  input wire logic standby_after_fill,
  output logic fifo_full,
  output logic fifo_empty,
  // parallel sample port
  output logic parallel_port_clock,
  output logic [11:0] parallel_port_data,
  // serial sample port
  input wire logic serial_port_clock_pin_in,
  output logic serial_port_clock_pin_out,
  output logic serial_port_clock_pin_oe,
  input wire logic serial_frame_sync_pin_in,
  output logic serial_frame_sync_pin_out,
  output logic serial_frame_sync_pin_oe,
  output logic serial_data_out
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int NPIN = 7;
  logic [NPIN-1:0] pins, s1_q, s2_q, s3_q, pin_q, prev_q, rise, fall;
  assign pins = {serial_frame_sync_pin_in, serial_port_clock_pin_in, dump_pin, fill_pin,
                 cfg_sdio_in, cfg_sclk, cfg_csb_n};

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      // all stages start at the reset level of pin_q, so no false rising edge follows reset
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      prev_q <= '1;
    end else if (clk_en) begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      prev_q <= pin_q;
    end
  end

  // a change is accepted only once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          pin_q[gi] <= 1'b1;
        end else if (clk_en && s2_q[gi] == s3_q[gi]) begin
          pin_q[gi] <= s2_q[gi];
        end
      end
    end
  endgenerate

  assign rise = pin_q & ~prev_q;
  assign fall = ~pin_q & prev_q;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] settle_lo_q, settle_hi_q, start_lo_q;
  logic [5:0] start_hi_q;
  logic [4:0] pdiv_q, sdiv_q, pattern_q;
  cfr_pkg::cfr_mode_t mode_q;
  cfr_pkg::cfr_state_t st_q;
  logic full_q, over_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] shin_q, instr_q;
  logic [7:0] shout_q;
  logic [15:0] new_instr;
  logic [7:0] wr_byte;
  logic spi_pop;

  // buffer head, shared by all consumers
  logic [11:0] buf_q [0:1];
  logic [1:0] cnt_q;
  logic rp_q, wp_q;
  logic buf_valid;
  logic [11:0] head;
  assign buf_valid = (cnt_q != 2'h0);
  assign head = buf_q[rp_q];

  function automatic logic [7:0] read_reg(input logic [12:0] a);
    unique case (a)
      `CFR_ADDR_SETTLE_LO: read_reg = settle_lo_q;
      `CFR_ADDR_SETTLE_HI: read_reg = settle_hi_q;
      `CFR_ADDR_READBACK: read_reg = {6'h00, mode_q};
      `CFR_ADDR_FLAGS: read_reg = {6'h00, over_q, full_q};
      `CFR_ADDR_SAMPLE_LO: read_reg = buf_valid ? head[7:0] : 8'h00;
      `CFR_ADDR_SAMPLE_HI: read_reg = buf_valid ? {4'h0, head[11:8]} : 8'h00;
      `CFR_ADDR_START_LO: read_reg = start_lo_q;
      `CFR_ADDR_START_HI: read_reg = {2'h0, start_hi_q};
      `CFR_ADDR_PDIV: read_reg = {3'h0, pdiv_q};
      `CFR_ADDR_SDIV: read_reg = {3'h0, sdiv_q};
      `CFR_ADDR_PATTERN: read_reg = {3'h0, pattern_q};
      default: read_reg = 8'h00;
    endcase
  endfunction

  assign new_instr = {shin_q[14:0], pin_q[2]};
  assign wr_byte = {shin_q[6:0], pin_q[2]};

  // serial bus framing: sample on rising clock, drive on falling clock
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_q <= 5'h00;
      shin_q <= 16'h0000;
      instr_q <= 16'h0000;
      shout_q <= 8'h00;
    end else if (clk_en) begin
      if (pin_q[0]) begin
        bit_cnt_q <= 5'h00;
      end else if (rise[1]) begin
        shin_q <= new_instr;
        if (bit_cnt_q != `CFR_FRAME_LAST) begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
        if (bit_cnt_q == `CFR_INSTR_LAST) begin
          instr_q <= new_instr;
          shout_q <= read_reg(new_instr[12:0]);
        end
      end else if (fall[1] && bit_cnt_q > `CFR_DATA_FIRST) begin
        shout_q <= {shout_q[6:0], 1'b0};
      end
    end
  end

  assign spi_pop = !pin_q[0] && rise[1] && bit_cnt_q == `CFR_INSTR_LAST
                   && new_instr[`CFR_RW_BIT] && new_instr[12:0] == `CFR_ADDR_SAMPLE_HI
                   && mode_q == cfr_pkg::MODE_OFF && buf_valid;
  assign cfg_sdio_out = shout_q[7];
  assign cfg_sdio_oe = !pin_q[0] && instr_q[`CFR_RW_BIT] && bit_cnt_q >= `CFR_DATA_FIRST;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      settle_lo_q <= `CFR_RST_BYTE;
      settle_hi_q <= `CFR_RST_BYTE;
      mode_q <= cfr_pkg::MODE_OFF;
      start_lo_q <= `CFR_RST_BYTE;
      start_hi_q <= 6'h00;
      pdiv_q <= `CFR_RST_DIV;
      sdiv_q <= `CFR_RST_DIV;
      pattern_q <= 5'h00;
    end else if (clk_en && !pin_q[0] && rise[1] && bit_cnt_q == `CFR_FRAME_LAST
                 && !instr_q[`CFR_RW_BIT]) begin
      unique case (instr_q[12:0])
        `CFR_ADDR_SETTLE_LO: settle_lo_q <= wr_byte;
        `CFR_ADDR_SETTLE_HI: settle_hi_q <= wr_byte;
        `CFR_ADDR_READBACK: mode_q <= cfr_pkg::cfr_mode_t'(wr_byte[1:0]);
        `CFR_ADDR_START_LO: start_lo_q <= wr_byte;
        `CFR_ADDR_START_HI: start_hi_q <= wr_byte[5:0];
        `CFR_ADDR_PDIV: pdiv_q <= wr_byte[4:0];
        `CFR_ADDR_SDIV: sdiv_q <= wr_byte[4:0];
        `CFR_ADDR_PATTERN: pattern_q <= wr_byte[4:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // capture sequencer
  // ----------------------------------------
  logic [14:0] total, wr_cnt_q;
  logic [15:0] settle_q;
  logic [13:0] rd_addr_q;
  logic [14:0] lfsr_q;
  logic powered_q, rd_valid_q, issue, ser_idle, more, port_busy;
  logic [11:0] fill_word, rd_data;
  logic fill_start;

  assign total = (15'(capture_block_count) + 15'h0001) << `CFR_BLOCK_SHIFT;
  assign fill_start = rise[3] && st_q != cfr_pkg::ST_DUMP;
  assign more = {1'b0, rd_addr_q} < total;
  assign issue = st_q == cfr_pkg::ST_DUMP && more && (cnt_q + {1'b0, rd_valid_q}) < 2'h2;

  always_comb begin
    unique case (pattern_q)
      `CFR_TP_ONES: fill_word = `CFR_PAT_ONES;
      `CFR_TP_PLUS1: fill_word = `CFR_PAT_PLUS1;
      `CFR_TP_PN: fill_word = lfsr_q[11:0];
      `CFR_TP_CHK_A: fill_word = wr_cnt_q[0] ? `CFR_PAT_CHK_5 : `CFR_PAT_CHK_A;
      `CFR_TP_CHK_5: fill_word = wr_cnt_q[0] ? `CFR_PAT_CHK_A : `CFR_PAT_CHK_5;
      default: fill_word = adc_data;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= cfr_pkg::ST_IDLE;
      wr_cnt_q <= 15'h0000;
      settle_q <= 16'h0000;
      powered_q <= 1'b1;
      rd_addr_q <= 14'h0000;
    end else if (clk_en) begin
      if (fill_start && !powered_q) begin
        powered_q <= 1'b1;
        settle_q <= {settle_hi_q, settle_lo_q};
        st_q <= cfr_pkg::ST_SETTLE;
      end else if (fill_start) begin
        wr_cnt_q <= 15'h0000;
        st_q <= (st_q == cfr_pkg::ST_SETTLE) ? cfr_pkg::ST_SETTLE : cfr_pkg::ST_FILL;
      end else begin
        unique case (st_q)
          cfr_pkg::ST_IDLE: ;
          cfr_pkg::ST_SETTLE: begin
            if (settle_q == 16'h0000) begin
              wr_cnt_q <= 15'h0000;
              st_q <= cfr_pkg::ST_FILL;
            end else begin
              settle_q <= settle_q - 16'h0001;
            end
          end
          cfr_pkg::ST_FILL: begin
            wr_cnt_q <= wr_cnt_q + 15'h0001;
            if (wr_cnt_q + 15'h0001 == total) begin
              st_q <= cfr_pkg::ST_FULL;
              powered_q <= !standby_after_fill;
            end
          end
          cfr_pkg::ST_FULL: begin
            // dump is ignored until capture has completed
            if (pin_q[4]) begin
              rd_addr_q <= {start_hi_q, start_lo_q};
              st_q <= cfr_pkg::ST_DUMP;
            end
          end
          cfr_pkg::ST_DUMP: begin
            if (issue) begin
              rd_addr_q <= rd_addr_q + 14'h0001;
            end
            if (!more && !rd_valid_q && !buf_valid && !port_busy) begin
              st_q <= cfr_pkg::ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      full_q <= 1'b0;
      over_q <= 1'b0;
      lfsr_q <= `CFR_RST_PN;
    end else if (clk_en) begin
      if (st_q == cfr_pkg::ST_FILL) begin
        lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
      end
      // a set in the same cycle as the fill-start clear wins
      if (st_q == cfr_pkg::ST_FILL && adc_over_range) begin
        over_q <= 1'b1;
      end else if (fill_start) begin
        over_q <= 1'b0;
      end
      if (st_q == cfr_pkg::ST_FILL && wr_cnt_q + 15'h0001 == total) begin
        full_q <= 1'b1;
      end else if (fill_start || st_q == cfr_pkg::ST_DUMP) begin
        full_q <= 1'b0;
      end
    end
  end

  cfr_sample_mem u_mem (
    .clock(clock),
    .clk_en(clk_en),
    .wr_en(st_q == cfr_pkg::ST_FILL),
    .wr_addr(wr_cnt_q[13:0]),
    .wr_data(fill_word),
    .rd_en(issue),
    .rd_addr(rd_addr_q),
    .rd_data(rd_data)
  );

  // ----------------------------------------
  // two-entry output buffer
  // ----------------------------------------
  logic pop, par_pop, ser_pop;
  assign pop = par_pop | ser_pop | spi_pop;

  // credit check on issue keeps the read in flight from overrunning the buffer
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid_q <= 1'b0;
      cnt_q <= 2'h0;
      rp_q <= 1'b0;
      wp_q <= 1'b0;
    end else if (clk_en) begin
      rd_valid_q <= issue;
      if (rd_valid_q) begin
        wp_q <= !wp_q;
      end
      if (pop) begin
        rp_q <= !rp_q;
      end
      cnt_q <= cnt_q + {1'b0, rd_valid_q} - {1'b0, pop};
    end
  end

  always_ff @(posedge clock) begin
    if (clk_en && rd_valid_q) begin
      buf_q[wp_q] <= rd_data;
    end
  end

  // ----------------------------------------
  // output ports
  // ----------------------------------------
  logic [4:0] pcnt_q, scnt_q, phalf, shalf;
  logic pclk_q, sclk_q, ptick, stick, sdfs_q, ser_fall, ser_frame;
  logic [11:0] pdata_q, sh_q;
  logic [3:0] sbits_q;
  logic par_run, ser_run;

  // a zero field would stall the divider, so it behaves as one
  assign phalf = (pdiv_q == 5'h00) ? 5'h01 : pdiv_q;
  assign shalf = (sdiv_q == 5'h00) ? 5'h01 : sdiv_q;
  assign par_run = st_q == cfr_pkg::ST_DUMP && mode_q == cfr_pkg::MODE_PAR;
  assign ser_run = st_q == cfr_pkg::ST_DUMP && mode_q == cfr_pkg::MODE_SER;
  assign ptick = par_run && pcnt_q == phalf - 5'h01;
  assign stick = ser_run && scnt_q == shalf - 5'h01;
  assign par_pop = ptick && !pclk_q && buf_valid;
  assign ser_fall = (stick && sclk_q) || (mode_q == cfr_pkg::MODE_SLAVE && fall[5]);
  assign ser_frame = mode_q == cfr_pkg::MODE_SER || pin_q[6];
  assign ser_idle = sbits_q <= 4'h1;
  assign ser_pop = ser_fall && ser_idle && buf_valid && ser_frame;
  // dump ends only after the last bit has been clocked out and the port clock is low
  assign port_busy = sbits_q != 4'h0 || pclk_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pcnt_q <= 5'h00;
      pclk_q <= 1'b0;
      pdata_q <= 12'h000;
    end else if (clk_en) begin
      if (!par_run) begin
        pcnt_q <= 5'h00;
        pclk_q <= 1'b0;
      end else if (ptick) begin
        pcnt_q <= 5'h00;
        pclk_q <= !pclk_q;
        if (par_pop) begin
          pdata_q <= head;
        end
      end else begin
        pcnt_q <= pcnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scnt_q <= 5'h00;
      sclk_q <= 1'b0;
    end else if (clk_en) begin
      if (!ser_run) begin
        scnt_q <= 5'h00;
        sclk_q <= 1'b0;
      end else if (stick) begin
        scnt_q <= 5'h00;
        sclk_q <= !sclk_q;
      end else begin
        scnt_q <= scnt_q + 5'h01;
      end
    end
  end

  // shifter loads on a falling serial clock, msb first
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sh_q <= 12'h000;
      sbits_q <= 4'h0;
      sdfs_q <= 1'b0;
    end else if (clk_en && ser_fall) begin
      if (ser_pop) begin
        sh_q <= head;
        sbits_q <= `CFR_WORD_BITS;
        sdfs_q <= 1'b1;
      end else begin
        sh_q <= {sh_q[10:0], 1'b0};
        sbits_q <= (sbits_q == 4'h0) ? 4'h0 : sbits_q - 4'h1;
        sdfs_q <= 1'b0;
      end
    end
  end

  assign serial_data_out = sh_q[11];
  assign serial_port_clock_pin_out = sclk_q;
  assign serial_port_clock_pin_oe = mode_q == cfr_pkg::MODE_SER;
  assign serial_frame_sync_pin_out = sdfs_q && mode_q == cfr_pkg::MODE_SER;
  assign serial_frame_sync_pin_oe = mode_q == cfr_pkg::MODE_SER;
  assign parallel_port_clock = pclk_q;
  assign parallel_port_data = pdata_q;
  assign converter_power_up = powered_q;
  assign fifo_full = full_q;
  assign fifo_empty = st_q != cfr_pkg::ST_FULL && !(st_q == cfr_pkg::ST_DUMP);

endmodule

// file: test/cfr_capture_monitor.sv
`timescale 1ns/1ps

module cfr_capture_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // capture control
  input wire logic fill_pin,
  input wire logic dump_pin,
  input wire logic standby_after_fill,
  input wire logic converter_power_up,
  input wire logic fifo_full,
  input wire logic fifo_empty,
  // sample ports
  input wire logic parallel_port_clock,
  input wire logic [11:0] parallel_port_data,
  input wire logic serial_port_clock_pin_out,
  input wire logic serial_port_clock_pin_oe,
  input wire logic serial_frame_sync_pin_out,
  input wire logic serial_frame_sync_pin_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_full_not_empty: assert property (fifo_full |-> !fifo_empty)
    else $error("full flag raised while empty flag high");
  // six quiet samples cover the pin synchroniser latency
  chk_full_holds: assert property ((!fill_pin && !dump_pin)[*6] ##0 fifo_full |=> fifo_full)
    else $error("full flag dropped without fill or dump");
  chk_no_output_full: assert property (fifo_full |-> !parallel_port_clock && !serial_port_clock_pin_out)
    else $error("sample port active before dump");
  chk_pclk_in_dump: assert property (parallel_port_clock |-> !fifo_empty)
    else $error("parallel clock running while empty");
  chk_pdata_on_rise: assert property ($changed(parallel_port_data) |-> $rose(parallel_port_clock))
    else $error("parallel data changed off a clock rise");
  chk_sclk_driven: assert property (serial_port_clock_pin_out |-> serial_port_clock_pin_oe)
    else $error("serial clock high without output enable");
  chk_fsync_driven: assert property (serial_frame_sync_pin_out |-> serial_frame_sync_pin_oe)
    else $error("frame sync high without output enable");
  chk_one_port: assert property (serial_port_clock_pin_oe |-> !parallel_port_clock)
    else $error("both sample ports active");
  chk_power_down: assert property ($fell(converter_power_up) |-> standby_after_fill ##[0:2] fifo_full)
    else $error("converter powered down outside fill end");
  cov_fill_done: cover property ($rose(fifo_full));
  cov_par_clock: cover property ($rose(parallel_port_clock));
  cov_ser_clock: cover property ($rose(serial_port_clock_pin_out));
endmodule

bind cfr_capture_ctrl cfr_capture_monitor u_mon (.clock, .sys_rst, .fill_pin, .dump_pin,
  .standby_after_fill, .converter_power_up, .fifo_full, .fifo_empty, .parallel_port_clock,
  .parallel_port_data, .serial_port_clock_pin_out, .serial_port_clock_pin_oe,
  .serial_frame_sync_pin_out, .serial_frame_sync_pin_oe);

// file: test/cfr_host_port.sv
`timescale 1ns/1ps

// host receiver of the serial sample port, msb first, 12 bits a word
module cfr_host_port (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // serial sample port lines
  input wire logic sck,
  input wire logic fs,
  input wire logic sd,
  // received words
  output logic [7:0] words_q,
  output logic [11:0] last_q
);
  logic sck_q;
  logic [3:0] n_q;
  logic [10:0] sh_q;
  // ----------------------------------------
  // word assembly on rising serial clock
  // ----------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sck_q <= 1'h0;
      n_q <= 4'h0;
      sh_q <= 11'h000;
      words_q <= 8'h00;
      last_q <= 12'h000;
    end else begin
      sck_q <= sck;
      if (sck && !sck_q && fs) begin
        sh_q <= {10'h000, sd};
        n_q <= 4'h1;
      end else if (sck && !sck_q && n_q != 4'h0) begin
        sh_q <= {sh_q[9:0], sd};
        n_q <= n_q + 4'h1;
        if (n_q == 4'hb) begin
          n_q <= 4'h0;
          words_q <= words_q + 8'h01;
          last_q <= {sh_q, sd};
        end
      end
    end
  end
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
`include "cfr_capture_regs.svh"

module tb;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic clock, sys_rst, csb_n, sclk, sdi, fill, dump, stby, orng, pclk_q, sck_h, fs_h, oe_seen;
  logic sdo, sdo_oe, pwr, full, empty, pclk, sck_o, sck_oe, fs_o, fs_oe, sdata;
  logic [11:0] pdata, lastw, pw, adc;
  logic [7:0] words, rv, bc;
  int n_errors = 0, checks = 0, cyc = 0, prise = 0, pper = 0, t1, t2;
  // host drives both sample port lines while the device is not driving
  wire sck_w = sck_oe ? sck_o : sck_h;
  wire fs_w = fs_oe ? fs_o : fs_h;
  logic [12:0] ra [12] = '{`CFR_ADDR_SETTLE_LO, `CFR_ADDR_SETTLE_HI, `CFR_ADDR_READBACK,
    `CFR_ADDR_FLAGS, `CFR_ADDR_SAMPLE_LO, `CFR_ADDR_SAMPLE_HI, `CFR_ADDR_START_LO,
    `CFR_ADDR_START_HI, `CFR_ADDR_PDIV, `CFR_ADDR_SDIV, `CFR_ADDR_PATTERN, 13'h0108};
  logic [7:0] rx [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h04, 8'h04, 8'h00, 8'h00};

  cfr_capture_ctrl DUT (.clock(clock), .sys_rst(sys_rst), .clk_en(1'h1),
    .cfg_csb_n(csb_n), .cfg_sclk(sclk), .cfg_sdio_in(sdi), .cfg_sdio_out(sdo),
    .cfg_sdio_oe(sdo_oe), .adc_data(adc), .adc_over_range(orng),
    .converter_power_up(pwr), .fill_pin(fill), .dump_pin(dump), .capture_block_count(bc),
    .standby_after_fill(stby), .fifo_full(full), .fifo_empty(empty),
    .parallel_port_clock(pclk), .parallel_port_data(pdata),
    .serial_port_clock_pin_in(sck_w), .serial_port_clock_pin_out(sck_o),
    .serial_port_clock_pin_oe(sck_oe), .serial_frame_sync_pin_in(fs_w),
    .serial_frame_sync_pin_out(fs_o), .serial_frame_sync_pin_oe(fs_oe),
    .serial_data_out(sdata));
  cfr_host_port u_host (.clock(clock), .sys_rst(sys_rst), .sck(sck_w), .fs(fs_w), .sd(sdata),
    .words_q(words), .last_q(lastw));

  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  // parallel clock period and last word, plus the hang limit
  always @(posedge clock) begin
    cyc++;
    pclk_q <= pclk;
    if (pclk && !pclk_q) begin
      pper = cyc - prise;
      prise = cyc;
      pw = pdata;
    end
    if (cyc == 40000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      complete_run();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // 24-bit frame; sclk phases of six clocks outlast the pin synchroniser
  task automatic xfer(input logic r, input logic [12:0] a, input logic [7:0] wd);
    logic [23:0] f;
    f = {r, 2'h0, a, wd};
    csb_n = 1'h0;
    for (int i = 23; i >= 0; i--) begin
      sdi = f[i];
      tick(6);
      sclk = 1'h1;
      tick(6);
      if (i < 8) rv[i] = sdo;
      if (i == 0) oe_seen = sdo_oe;
      sclk = 1'h0;
    end
    tick(6);
    csb_n = 1'h1;
    tick(6);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    xfer(1'h1, a, 8'h00);
    chk({8'h00, rv}, {8'h00, e});
    chk({15'h0000, oe_seen}, 16'h0001);
  endtask
  task automatic wrd(input logic [12:0] a, input logic [7:0] w, input logic [7:0] e);
    xfer(1'h0, a, w);
    rd(a, e);
  endtask
  task automatic do_fill(input logic [7:0] pat, input logic sb, output int c);
    xfer(1'h0, `CFR_ADDR_PATTERN, pat);
    stby = sb;
    fill = 1'h1;
    c = 0;
    do begin
      tick(1);
      c++;
      if (c == 3) fill = 1'h0;
    end while (!(full === 1'h1 && c > 8) && c < 3000);
  endtask
  task automatic drain(input logic [7:0] mode);
    int c;
    c = 0;
    xfer(1'h0, `CFR_ADDR_READBACK, mode);
    dump = 1'h1;
    while (empty !== 1'h1 && c < 8000) begin
      tick(1);
      c++;
    end
    dump = 1'h0;
    chk({15'h0000, empty}, 16'h0001);
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    sys_rst = 1'h1;
    csb_n = 1'h1;
    sclk = 1'h0;
    sdi = 1'h0;
    fill = 1'h0;
    dump = 1'h0;
    stby = 1'h0;
    orng = 1'h0;
    sck_h = 1'h1;
    fs_h = 1'h0;
    adc = 12'h000;
    bc = 8'h00;
    tick(10);
    sys_rst = 1'h0;
    tick(4);
    for (int i = 0; i < 12; i++) rd(ra[i], rx[i]);
    wrd(`CFR_ADDR_READBACK, 8'hff, 8'h03);
    wrd(`CFR_ADDR_FLAGS, 8'hff, 8'h00);
    wrd(`CFR_ADDR_SAMPLE_HI, 8'hff, 8'h00);
    wrd(`CFR_ADDR_START_HI, 8'hff, 8'h3f);
    wrd(`CFR_ADDR_PDIV, 8'hff, 8'h1f);
    wrd(`CFR_ADDR_SDIV, 8'hff, 8'h1f);
    wrd(`CFR_ADDR_PATTERN, 8'hff, 8'h1f);
    wrd(13'h0108, 8'hff, 8'h00);
    wrd(`CFR_ADDR_READBACK, 8'h00, 8'h00);
    wrd(`CFR_ADDR_START_HI, 8'h00, 8'h00);
    wrd(`CFR_ADDR_START_LO, 8'h3e, 8'h3e);
    wrd(`CFR_ADDR_PDIV, 8'h0f, 8'h0f);
    wrd(`CFR_ADDR_SDIV, 8'h04, 8'h04);
    wrd(`CFR_ADDR_SETTLE_LO, 8'h20, 8'h20);
    wrd(`CFR_ADDR_SETTLE_HI, 8'h01, 8'h01);
    // checkerboard capture read back over the bus from offset 62
    do_fill(8'h03, 1'h0, t1);
    chkn(t1, 66, 74);
    rd(`CFR_ADDR_FLAGS, 8'h01);
    dump = 1'h1;
    rd(`CFR_ADDR_SAMPLE_LO, 8'haa);
    rd(`CFR_ADDR_SAMPLE_HI, 8'h0a);
    rd(`CFR_ADDR_SAMPLE_LO, 8'h55);
    rd(`CFR_ADDR_SAMPLE_HI, 8'h05);
    drain(8'h00);
    // standby after fill, then a fill that must wait the settle count
    do_fill(8'h06, 1'h1, t2);
    tick(2);
    chk({15'h0000, pwr}, 16'h0000);
    orng = 1'h1;
    do_fill(8'h06, 1'h0, t2);
    orng = 1'h0;
    chkn(t2 - t1, 289, 289);
    rd(`CFR_ADDR_FLAGS, 8'h03);
    drain(8'h01);
    chkn(pper, 30, 30);
    chk({4'h0, pw}, 16'h0fff);
    // serial master readout of a two-block capture at the reset divide ratio
    bc = 8'h01;
    do_fill(8'h05, 1'h0, t2);
    chkn(t2 - t1, 64, 64);
    drain(8'h02);
    chk({8'h00, words}, 16'h0042);
    chk({4'h0, lastw}, 16'h0001);
    // slave readout of converter data, host drives clock and frame sync
    bc = 8'h00;
    adc = 12'h3c6;
    do_fill(8'h00, 1'h0, t2);
    xfer(1'h0, `CFR_ADDR_READBACK, 8'h03);
    dump = 1'h1;
    tick(20);
    for (int k = 0; k < 25; k++) begin
      fs_h = (k % 12 == 0);
      tick(3);
      sck_h = 1'h0;
      tick(6);
      sck_h = 1'h1;
      tick(3);
    end
    drain(8'h03);
    chk({8'h00, words}, 16'h0044);
    chk({4'h0, lastw}, 16'h03c6);
    complete_run();
  end
endmodule
